// >>> design/if_front_end_pkg.sv
// Shared constants, types and lookup functions for the IF receive front end
`default_nettype none
package if_front_end_pkg;
	// ****************************************************************
	// Register offsets (word addresses on the control port)
	// ****************************************************************
	localparam logic [5:0] REG_MAIN_CTRL = 6'h01;
	localparam logic [5:0] REG_CH0_ATT = 6'h03;
	localparam logic [5:0] REG_CH0_WAIT = 6'h04;
	localparam logic [5:0] REG_TUNE_HI = 6'h05;
	localparam logic [5:0] REG_TUNE_LO = 6'h06;
	localparam logic [5:0] REG_PHASE_HI = 6'h07;
	localparam logic [5:0] REG_PHASE_LO = 6'h08;
	localparam logic [5:0] REG_DEC_RATE = 6'h09;
	localparam logic [5:0] REG_SCALE_SHIFT = 6'h0a;
	localparam logic [5:0] REG_FIR1_CFG = 6'h0b;
	localparam logic [5:0] REG_FIR2A_CFG = 6'h0c;
	localparam logic [5:0] REG_FIR2B_CFG = 6'h0d;
	localparam logic [5:0] REG_FIR_LEN = 6'h0e;
	localparam logic [5:0] REG_CH1_ATT = 6'h0f;
	localparam logic [5:0] REG_CH1_WAIT = 6'h10;
	localparam logic [5:0] REG_CH0_LIMIT = 6'h2e;
	localparam logic [5:0] REG_CH1_LIMIT = 6'h2f;
	localparam logic [5:0] REG_EVENT_STATUS = 6'h30;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CTRL_CONV_EN0 = 0;
	localparam int CTRL_CONV_EN1 = 1;
	localparam int CTRL_DOUBLE_GAIN0 = 2;
	localparam int CTRL_DOUBLE_GAIN1 = 3;
	localparam int CTRL_DOWNCONV_EN = 4;
	localparam int CTRL_PHASE_SYNC = 6;
	localparam int SCALE_LSB = 6;
	localparam int SHIFT_LSB = 0;
	localparam int ST_OVR0 = 0;
	localparam int ST_OVR1 = 1;
	localparam int ST_LIM0 = 2;
	localparam int ST_LIM1 = 3;

	// ****************************************************************
	// Reset values and limits
	// ****************************************************************
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] RST_DEC_RATE = 16'h0004;
	localparam logic [8:0] DEC_MIN = 9'h004;
	localparam logic [8:0] DEC_MAX = 9'h100;
	localparam int SCALE_FRAC_BITS = 5;
	localparam logic [11:0] FULL_SCALE_POS = 12'h7ff;
	localparam logic [11:0] FULL_SCALE_NEG = 12'h800;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [5:0] addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [11:0] ch1;
		logic [11:0] ch0;
	} conv_pair_t;

	typedef struct packed {
		logic [15:0] i;
		logic [15:0] q;
	} iq_t;

	// Attenuator gains in 1.15 unsigned, 3 dB per step; code 7 clamps to code 6
	function automatic logic [15:0] att_coef(input logic [2:0] code);
		unique case (code)
			3'h0: att_coef = 16'h8000;
			3'h1: att_coef = 16'h5a9e;
			3'h2: att_coef = 16'h4027;
			3'h3: att_coef = 16'h2d6b;
			3'h4: att_coef = 16'h2027;
			3'h5: att_coef = 16'h16c3;
			default: att_coef = 16'h101d;
		endcase
	endfunction : att_coef

	// Quarter-wave sine table, 17 points, amplitude 2047
	function automatic logic [11:0] quarter_sine(input logic [4:0] idx);
		unique case (idx)
			5'h00: quarter_sine = 12'h000;
			5'h01: quarter_sine = 12'h0c9;
			5'h02: quarter_sine = 12'h18f;
			5'h03: quarter_sine = 12'h252;
			5'h04: quarter_sine = 12'h30f;
			5'h05: quarter_sine = 12'h3c5;
			5'h06: quarter_sine = 12'h471;
			5'h07: quarter_sine = 12'h512;
			5'h08: quarter_sine = 12'h5a7;
			5'h09: quarter_sine = 12'h62f;
			5'h0a: quarter_sine = 12'h6a7;
			5'h0b: quarter_sine = 12'h70f;
			5'h0c: quarter_sine = 12'h763;
			5'h0d: quarter_sine = 12'h7a7;
			5'h0e: quarter_sine = 12'h7d8;
			5'h0f: quarter_sine = 12'h7f5;
			default: quarter_sine = 12'h7ff;
		endcase
	endfunction : quarter_sine

	// Full-cycle sine from the top six phase bits
	function automatic logic [11:0] wave_sine(input logic [5:0] ph);
		logic [11:0] mag;
		mag = ph[4] ? quarter_sine(5'h10 - {1'b0, ph[3:0]}) : quarter_sine({1'b0, ph[3:0]});
		wave_sine = ph[5] ? 12'(-mag) : mag;
	endfunction : wave_sine
endpackage : if_front_end_pkg
`default_nettype wire

// >>> design/if_front_end.sv
// IF receive front end: converter control, events, attenuators, mixer, comb decimator
//
// Overview of operation
// - Enable bits give full or minimum bias per converter.
// - Each converter gain select bit low gives 1x, high gives 2x.
// - Full-scale samples raise an overflow event per converter.
// - Sample magnitude above channel limit raises a limit event.
// - Events latch in a readable status register regardless of masking.
// - Channel 0 attenuator, 3 dB steps, codes 0 to 6.
// - New attenuation loads delay counter; applies when counter reaches zero.
// - A newer attenuation write discards the pending one and restarts delay.
// - Channel 1 has an identical attenuator and delay counter.
// - Downconverter runs only while main control bit 4 is one.
// - Tuning word and initial phase are 32 bits from two halves.
// - I is sample times cosine, Q sample times sine of phase.
// - Sync high holds phase at initial value; low advances each clock while running.
// - Fifth-order comb decimator, rate 4 to 256.
// - Output gain is rate to the fifth times scale/32 over 2^shift.
`default_nettype none

// ********************************************************************
// Output FIFO with a registered head slot
// ********************************************************************
module sample_fifo
	import if_front_end_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic clkEn,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	// The head slot counts as one word, so the array keeps at most DEPTH-1
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("sample_fifo DEPTH must be a power of two, at least 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] count;
		logic headValid;
		logic [WIDTH-1:0] head;
	} fifo_state_t;

	fifo_state_t q;
	fifo_state_t n;

	assign inReady = (q.count < (AW + 1)'(DEPTH - 1));
	assign outValid = q.headValid;
	assign outData = q.head;

	// Push into the array, refill the head slot when it empties or is taken
	always_comb begin
		n = q;
		if (inValid && inReady) begin
			n.mem[q.wp] = inData;
			n.wp = q.wp + 1'b1;
		end
		if (q.headValid && outReady) begin
			n.headValid = 1'b0;
		end
		if (!n.headValid && q.count != '0) begin
			n.head = q.mem[q.rp];
			n.headValid = 1'b1;
			n.rp = q.rp + 1'b1;
		end
		n.count = q.count + (AW + 1)'(inValid && inReady) - (AW + 1)'(n.rp != q.rp);
	end

	// Clock enable low freezes the whole queue
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else if (clkEn) begin
			q <= n;
		end
	end
endmodule : sample_fifo

// ********************************************************************
// Front end top
// ********************************************************************
module if_front_end
	import if_front_end_pkg::*;
#(
	parameter int ACC_W = 56,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic clkEn,
	input wire reg_req_t regReq,
	output logic [15:0] regRdata,
	input wire conv_pair_t convSample,
	output logic [1:0] convFullBias,
	output logic [1:0] convDoubleGain,
	output logic [1:0] overflowEvent,
	output logic [1:0] limitEvent,
	output logic [11:0] chan1AttenuatedSample,
	output logic sampleValid,
	input wire logic sampleReady,
	output iq_t sampleData
);
	// Growth of a rate-256 fifth-order comb is 40 bits on the 13-bit mixer output
	if (ACC_W < 54 || ACC_W > 56) begin : g_chk
		$error("if_front_end ACC_W must be 54 to 56");
	end

	typedef struct packed {
		logic [15:0] ctrl;
		logic [1:0][15:0] attReg;
		logic [1:0][15:0] waitReg;
		logic [31:0] tune;
		logic [31:0] initPhase;
		logic [15:0] decReg;
		logic [15:0] scaleShift;
		logic [3:0][15:0] firCfg;
		logic [1:0][15:0] limReg;
		logic [3:0] status;
		logic [15:0] rdata;
		logic [1:0] fullBias;
		logic [1:0] dblGain;
		logic [1:0] ovrEv;
		logic [1:0] limEv;
		logic [1:0][2:0] attPend;
		logic [1:0][2:0] attCur;
		logic [1:0][15:0] attCnt;
		logic [1:0] attBusy;
		logic [1:0][11:0] attSample;
		logic [31:0] phase;
		logic [12:0] mixI;
		logic [12:0] mixQ;
		logic [8:0] decCnt;
		logic [4:0][ACC_W-1:0] intI;
		logic [4:0][ACC_W-1:0] intQ;
		logic [4:0][ACC_W-1:0] dlyI;
		logic [4:0][ACC_W-1:0] dlyQ;
		logic enPrev;
		logic pushValid;
		iq_t pushData;
	} fe_state_t;

	fe_state_t q;
	fe_state_t n;
	logic fifoInReady;
	logic [8:0] rate;
	logic run;
	logic stall;
	logic [ACC_W-1:0] combI;
	logic [ACC_W-1:0] combQ;
	logic [ACC_W-1:0] tmpI;
	logic [ACC_W-1:0] tmpQ;
	logic [62:0] prodI;
	logic [62:0] prodQ;
	logic [11:0] mag;
	logic [28:0] attProd;
	logic [23:0] mulI;
	logic [23:0] mulQ;

	// Saturate a scaled comb output to the 16-bit output word
	function automatic logic [15:0] sat16(input logic [62:0] v);
		if (!v[62] && v[61:15] != '0) begin
			sat16 = 16'h7fff;
		end else if (v[62] && v[61:15] != '1) begin
			sat16 = 16'h8000;
		end else begin
			sat16 = v[15:0];
		end
	endfunction : sat16

	// Out-of-range rates are clamped so the decimator never stalls or overruns
	assign rate = (q.decReg[8:0] < DEC_MIN) ? DEC_MIN :
		(q.decReg[8:0] > DEC_MAX) ? DEC_MAX : q.decReg[8:0];

	// A full FIFO with a word waiting freezes the datapath rather than losing it
	assign stall = q.pushValid && !fifoInReady;
	assign run = q.ctrl[CTRL_DOWNCONV_EN] && !stall;

	assign regRdata = q.rdata;
	assign convFullBias = q.fullBias;
	assign convDoubleGain = q.dblGain;
	assign overflowEvent = q.ovrEv;
	assign limitEvent = q.limEv;
	assign chan1AttenuatedSample = q.attSample[1];

	// Next-state logic for registers, events, attenuators and datapath
	always_comb begin
		n = q;
		combI = '0;
		combQ = '0;
		tmpI = '0;
		tmpQ = '0;
		prodI = '0;
		prodQ = '0;
		mag = '0;
		attProd = '0;
		mulI = '0;
		mulQ = '0;

		// Register writes; attenuation writes restart the delay and drop any pending code
		if (regReq.wr) begin
			unique case (regReq.addr)
				REG_MAIN_CTRL: n.ctrl = regReq.wdata;
				REG_CH0_WAIT: n.waitReg[0] = regReq.wdata;
				REG_CH1_WAIT: n.waitReg[1] = regReq.wdata;
				REG_TUNE_HI: n.tune[31:16] = regReq.wdata;
				REG_TUNE_LO: n.tune[15:0] = regReq.wdata;
				REG_PHASE_HI: n.initPhase[31:16] = regReq.wdata;
				REG_PHASE_LO: n.initPhase[15:0] = regReq.wdata;
				REG_DEC_RATE: n.decReg = regReq.wdata;
				REG_SCALE_SHIFT: n.scaleShift = regReq.wdata;
				REG_FIR1_CFG: n.firCfg[0] = regReq.wdata;
				REG_FIR2A_CFG: n.firCfg[1] = regReq.wdata;
				REG_FIR2B_CFG: n.firCfg[2] = regReq.wdata;
				REG_FIR_LEN: n.firCfg[3] = regReq.wdata;
				REG_CH0_LIMIT: n.limReg[0] = regReq.wdata;
				REG_CH1_LIMIT: n.limReg[1] = regReq.wdata;
				default: ;
			endcase
		end

		// Attenuator delay counters, one per channel
		for (int c = 0; c < 2; c++) begin
			if (q.attBusy[c]) begin
				if (q.attCnt[c] == '0) begin
					n.attCur[c] = q.attPend[c];
					n.attBusy[c] = 1'b0;
				end else begin
					n.attCnt[c] = q.attCnt[c] - 16'h0001;
				end
			end
			if (regReq.wr && regReq.addr == (c == 0 ? REG_CH0_ATT : REG_CH1_ATT)) begin
				n.attReg[c] = regReq.wdata;
				n.attPend[c] = regReq.wdata[2:0];
				n.attCnt[c] = q.waitReg[c];
				n.attBusy[c] = 1'b1;
			end
		end

		// Converter control follows the main control register
		n.fullBias = {q.ctrl[CTRL_CONV_EN1], q.ctrl[CTRL_CONV_EN0]};
		n.dblGain = {q.ctrl[CTRL_DOUBLE_GAIN1], q.ctrl[CTRL_DOUBLE_GAIN0]};

		// Over-range and magnitude monitors, attenuated samples
		for (int c = 0; c < 2; c++) begin
			n.ovrEv[c] = (convSample[c*12 +: 12] == FULL_SCALE_POS) ||
				(convSample[c*12 +: 12] == FULL_SCALE_NEG);
			mag = convSample[c*12+11] ? 12'(-convSample[c*12 +: 12]) : convSample[c*12 +: 12];
			n.limEv[c] = (mag > q.limReg[c][11:0]);
			attProd = 29'($signed(convSample[c*12 +: 12]) *
				$signed({1'b0, att_coef(q.attCur[c])}));
			n.attSample[c] = attProd[26:15];
		end

		// Sticky event status: a new event beats a same-cycle write-one clear
		if (regReq.wr && regReq.addr == REG_EVENT_STATUS) begin
			n.status = q.status & ~regReq.wdata[3:0];
		end
		n.status = n.status | {q.limEv, q.ovrEv};

		// Read data, one cycle after the strobe; unmapped words read zero
		if (regReq.rd) begin
			unique case (regReq.addr)
				REG_MAIN_CTRL: n.rdata = q.ctrl;
				REG_CH0_ATT: n.rdata = q.attReg[0];
				REG_CH0_WAIT: n.rdata = q.waitReg[0];
				REG_TUNE_HI: n.rdata = q.tune[31:16];
				REG_TUNE_LO: n.rdata = q.tune[15:0];
				REG_PHASE_HI: n.rdata = q.initPhase[31:16];
				REG_PHASE_LO: n.rdata = q.initPhase[15:0];
				REG_DEC_RATE: n.rdata = q.decReg;
				REG_SCALE_SHIFT: n.rdata = q.scaleShift;
				REG_FIR1_CFG: n.rdata = q.firCfg[0];
				REG_FIR2A_CFG: n.rdata = q.firCfg[1];
				REG_FIR2B_CFG: n.rdata = q.firCfg[2];
				REG_FIR_LEN: n.rdata = q.firCfg[3];
				REG_CH1_ATT: n.rdata = q.attReg[1];
				REG_CH1_WAIT: n.rdata = q.waitReg[1];
				REG_CH0_LIMIT: n.rdata = q.limReg[0];
				REG_CH1_LIMIT: n.rdata = q.limReg[1];
				REG_EVENT_STATUS: n.rdata = {12'h000, q.status};
				default: n.rdata = RST_ZERO;
			endcase
		end

		// Oscillator: sync holds the initial phase, otherwise advance while running
		if (q.ctrl[CTRL_PHASE_SYNC]) begin
			n.phase = q.initPhase;
		end else if (run) begin
			n.phase = q.phase + q.tune;
		end

		// Mixer and comb decimator advance only while running
		n.enPrev = q.ctrl[CTRL_DOWNCONV_EN];
		n.pushValid = stall;
		if (run) begin
			mulI = 24'($signed(q.attSample[0]) * $signed(wave_sine(q.phase[31:26] + 6'h10)));
			mulQ = 24'($signed(q.attSample[0]) * $signed(wave_sine(q.phase[31:26])));
			n.mixI = mulI[23:11];
			n.mixQ = mulQ[23:11];
			n.intI[0] = q.intI[0] + ACC_W'($signed(q.mixI));
			n.intQ[0] = q.intQ[0] + ACC_W'($signed(q.mixQ));
			for (int k = 1; k < 5; k++) begin
				n.intI[k] = q.intI[k] + q.intI[k-1];
				n.intQ[k] = q.intQ[k] + q.intQ[k-1];
			end
			if (q.decCnt >= rate - 9'h001) begin
				n.decCnt = '0;
				combI = q.intI[4];
				combQ = q.intQ[4];
				for (int k = 0; k < 5; k++) begin
					tmpI = combI - q.dlyI[k];
					tmpQ = combQ - q.dlyQ[k];
					n.dlyI[k] = combI;
					n.dlyQ[k] = combQ;
					combI = tmpI;
					combQ = tmpQ;
				end
				prodI = 63'($signed(combI) * $signed({1'b0, q.scaleShift[SCALE_LSB +: 6]}));
				prodQ = 63'($signed(combQ) * $signed({1'b0, q.scaleShift[SCALE_LSB +: 6]}));
				prodI = $signed(prodI) >>> (SCALE_FRAC_BITS + q.scaleShift[SHIFT_LSB +: 6]);
				prodQ = $signed(prodQ) >>> (SCALE_FRAC_BITS + q.scaleShift[SHIFT_LSB +: 6]);
				n.pushData = '{i: sat16(prodI), q: sat16(prodQ)};
				n.pushValid = 1'b1;
			end else begin
				n.decCnt = q.decCnt + 9'h001;
			end
		end

		// Re-enable starts from a cleared filter; disabled state simply holds
		if (q.ctrl[CTRL_DOWNCONV_EN] && !q.enPrev) begin
			n.intI = '0;
			n.intQ = '0;
			n.dlyI = '0;
			n.dlyQ = '0;
			n.decCnt = '0;
			n.mixI = '0;
			n.mixQ = '0;
			n.pushValid = 1'b0;
		end
	end

	// Single state register; clock enable low freezes everything
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
			q.decReg <= RST_DEC_RATE;
		end else if (clkEn) begin
			q <= n;
		end
	end

	// Output queue between the decimator and the sample consumer
	sample_fifo #(
		.WIDTH($bits(iq_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.clkEn(clkEn),
		.inValid(q.pushValid),
		.inReady(fifoInReady),
		.inData(q.pushData),
		.outValid(sampleValid),
		.outReady(sampleReady),
		.outData(sampleData)
	);
endmodule : if_front_end
`default_nettype wire

// >>> tb/if_front_end_checker.sv
// Port-level concurrent checks for the IF receive front end
`default_nettype none
module if_front_end_checker
	import if_front_end_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic clkEn,
	input wire reg_req_t regReq,
	input wire logic [15:0] regRdata,
	input wire conv_pair_t convSample,
	input wire logic [1:0] convFullBias,
	input wire logic [1:0] convDoubleGain,
	input wire logic [1:0] overflowEvent,
	input wire logic [1:0] limitEvent,
	input wire logic [11:0] chan1AttenuatedSample,
	input wire logic sampleValid,
	input wire logic sampleReady,
	input wire iq_t sampleData
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************************************
	// Helper logic
	// ****************************************************************
	logic [11:0] lim0_q, lim1_q;
	logic runSeen_q;
	logic wrTaken;
	logic [12:0] mag0, mag1;
	logic [1:0] ovrNow, limNow;
	assign wrTaken = clkEn && regReq.wr;
	// Mirror the limits, since the threshold in force is not visible at the ports
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lim0_q <= '0;
			lim1_q <= '0;
			runSeen_q <= 1'b0;
		end else if (wrTaken) begin
			if (regReq.addr == REG_CH0_LIMIT) lim0_q <= regReq.wdata[11:0];
			if (regReq.addr == REG_CH1_LIMIT) lim1_q <= regReq.wdata[11:0];
			if (regReq.addr == REG_MAIN_CTRL && regReq.wdata[CTRL_DOWNCONV_EN]) runSeen_q <= 1'b1;
		end
	end
	// Magnitude needs 13 bits so that the most negative code is not lost
	always_comb begin
		mag0 = convSample.ch0[11] ? 13'h0000 - {1'b1, convSample.ch0} : {1'b0, convSample.ch0};
		mag1 = convSample.ch1[11] ? 13'h0000 - {1'b1, convSample.ch1} : {1'b0, convSample.ch1};
		ovrNow[0] = convSample.ch0 == FULL_SCALE_POS || convSample.ch0 == FULL_SCALE_NEG;
		ovrNow[1] = convSample.ch1 == FULL_SCALE_POS || convSample.ch1 == FULL_SCALE_NEG;
		limNow = {mag1 > {1'b0, lim1_q}, mag0 > {1'b0, lim0_q}};
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	sequence s_ctrl_write;
		wrTaken && regReq.addr == REG_MAIN_CTRL ##1 clkEn;
	endsequence
	sequence s_stalled;
		sampleValid && !(sampleReady && clkEn);
	endsequence
	a_bias_follow: assert property (
		s_ctrl_write |=> convFullBias == $past(regReq.wdata[1:0], 2)) else $error("bias mode wrong");
	a_gain_follow: assert property (
		s_ctrl_write |=> convDoubleGain == $past(regReq.wdata[3:2], 2)) else $error("gain wrong");
	a_overflow_flags: assert property (
		clkEn |=> overflowEvent == $past(ovrNow)) else $error("overflow event wrong");
	a_limit_flags: assert property (
		clkEn |=> limitEvent == $past(limNow)) else $error("limit event wrong");
	a_unmapped_reads_zero: assert property (clkEn && regReq.rd
		&& !(regReq.addr inside {6'h01, [6'h03:6'h10], 6'h2e, 6'h2f, 6'h30})
		|=> regRdata == 16'h0000) else $error("unmapped read not zero");
	a_read_stands: assert property (!(clkEn && regReq.rd) |=> $stable(regRdata))
		else $error("read data moved");
	a_stall_hold: assert property (s_stalled |=> sampleValid && $stable(sampleData))
		else $error("stalled word changed");
	a_idle_quiet: assert property (!runSeen_q |-> !sampleValid)
		else $error("word before enable");
endmodule : if_front_end_checker
bind if_front_end if_front_end_checker u_chk (.ref_clk(ref_clk), .arst_n(arst_n),
	.clkEn(clkEn), .regReq(regReq), .regRdata(regRdata), .convSample(convSample),
	.convFullBias(convFullBias), .convDoubleGain(convDoubleGain),
	.overflowEvent(overflowEvent), .limitEvent(limitEvent),
	.chan1AttenuatedSample(chan1AttenuatedSample), .sampleValid(sampleValid),
	.sampleReady(sampleReady), .sampleData(sampleData));
`default_nettype wire

// >>> tb/if_converter_model.sv
// Behavioural model of the two IF sampling converters
`default_nettype none
module if_converter_model
	import if_front_end_pkg::*;
(
	input wire logic ref_clk,
	input wire logic [1:0] fullBias,
	input wire logic [1:0] doubleGain,
	input wire conv_pair_t level,
	output conv_pair_t sample
);
	timeunit 1ns;
	timeprecision 100ps;
	conv_pair_t last_q = '0;
	// Remember the last code taken while biased; an unknown bias at start-up leaves it alone
	always_ff @(negedge ref_clk) begin
		if (fullBias[0]) begin
			last_q.ch0 <= sample.ch0;
		end
		if (fullBias[1]) begin
			last_q.ch1 <= sample.ch1;
		end
	end
	// Minimum bias gives no usable data, so the output shows the inverse of the last good code
	always_comb begin
		sample.ch0 = fullBias[0] ? (doubleGain[0] ? level.ch0 << 1 : level.ch0) : ~last_q.ch0;
		sample.ch1 = fullBias[1] ? (doubleGain[1] ? level.ch1 << 1 : level.ch1) : ~last_q.ch1;
	end
endmodule : if_converter_model
`default_nettype wire

// >>> tb/if_front_end_bench.sv
// Self-checking bench for the IF receive front end
`default_nettype none
module if_front_end_bench
	import if_front_end_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [5:0] a; logic [15:0] d; int k; int eI; int eQ; int eG;} row_t;
	logic ref_clk, arst_n, clkEn, sampleValid, sampleReady;
	reg_req_t regReq;
	logic [15:0] regRdata, att1;
	conv_pair_t level, convSample;
	logic [1:0] convFullBias, convDoubleGain, overflowEvent, limitEvent;
	logic [11:0] chan1AttenuatedSample;
	iq_t sampleData;
	int err_total = 0;
	int tests_run = 0;
	int cycles = 0;
	// Register write, then a stream setting; expected attenuator step, I, Q, word spacing
	row_t rows [16] = '{'{REG_CH1_ATT, 16'h0001, 1, 999, 0, 4},
		'{REG_CH1_ATT, 16'h0002, 2, 999, 0, 4}, '{REG_CH1_ATT, 16'h0003, 3, 999, 0, 4},
		'{REG_CH1_ATT, 16'h0004, 4, 999, 0, 4}, '{REG_CH1_ATT, 16'h0005, 5, 999, 0, 4},
		'{REG_CH1_ATT, 16'h0006, 6, 999, 0, 4}, '{REG_CH1_ATT, 16'h0007, 6, 999, 0, 4},
		'{REG_CH1_ATT, 16'h0000, 0, 999, 0, 4}, '{REG_SCALE_SHIFT, 16'h040a, 0, 499, 0, 4},
		'{REG_SCALE_SHIFT, 16'h080a, 0, 999, 0, 4}, '{REG_PHASE_HI, 16'h4000, 0, 0, 999, 4},
		'{REG_DEC_RATE, 16'h0008, 0, 0, 31968, 8}, '{REG_DEC_RATE, 16'h0100, 0, 0, 32767, 256},
		'{REG_DEC_RATE, 16'h0003, 0, 0, 999, 4}, '{REG_TUNE_HI, 16'h4000, 0, 0, 999, 4},
		'{REG_MAIN_CTRL, 16'h0013, 0, 0, 0, 4}};
	assign att1 = {{4{chan1AttenuatedSample[11]}}, chan1AttenuatedSample};
	if_front_end u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .clkEn(clkEn), .regReq(regReq),
		.regRdata(regRdata), .convSample(convSample), .convFullBias(convFullBias),
		.convDoubleGain(convDoubleGain), .overflowEvent(overflowEvent),
		.limitEvent(limitEvent), .chan1AttenuatedSample(chan1AttenuatedSample),
		.sampleValid(sampleValid), .sampleReady(sampleReady), .sampleData(sampleData));
	if_converter_model u_conv (.ref_clk(ref_clk), .fullBias(convFullBias),
		.doubleGain(convDoubleGain), .level(level), .sample(convSample));
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick
	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	// Filter and attenuator outputs carry truncation, so a small window is allowed
	task automatic near(input string nm, input int e, input logic [15:0] g, input int tol);
		int s;
		s = int'($signed(g));
		tests_run++;
		if ($isunknown(g) || s > e + tol || s < e - tol) begin
			err_total++;
			$display("mismatch %s expected %0d seen %0d", nm, e, s);
		end
	endtask : near
	// Strobes drop and an extra cycle passes, so back-to-back calls never collide
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		regReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		tick(1);
		regReq.wr = 1'b0;
		tick(1);
	endtask : wr
	task automatic rdchk(input string nm, input logic [5:0] a, input logic [15:0] e);
		regReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		tick(1);
		cmp(nm, e, regRdata);
		regReq.rd = 1'b0;
		tick(1);
	endtask : rdchk
	task automatic words(input int n, output logic [15:0] i, output logic [15:0] q, output int gap);
		int got = 0;
		int t = 0;
		int last = 0;
		gap = 0;
		while (got < n && t < 4000) begin
			tick(1);
			t++;
			if (sampleValid === 1'b1) begin
				got++;
				gap = t - last;
				last = t;
				i = sampleData.i;
				q = sampleData.q;
			end
		end
		cmp("wordCount", 16'(n), 16'(got));
	endtask : words
	function automatic int attExp(input int lv, input int k);
		return $rtoi(lv * (10.0 ** (-0.15 * k)) + 0.5);
	endfunction : attExp
	task automatic wrap_up();
		$display("counts: %0d mismatches in %0d checks", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up
	// ****************************************************************
	// Clock, watchdog and main sequence
	// ****************************************************************
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// Longest path is the 256 rate row; the ceiling leaves ample margin
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 30000) begin
			err_total++;
			wrap_up();
		end
	end
	initial begin
		logic [15:0] vi, vq;
		int gap, n;
		clkEn = 1'b1;
		sampleReady = 1'b1;
		arst_n = 1'b0;
		regReq = '0;
		level = '{ch1: 12'd1000, ch0: 12'd1000};
		tick(3);
		arst_n = 1'b1;
		cmp("fullBias", 16'h0000, {14'h0, convFullBias});
		rdchk("ctrl", REG_MAIN_CTRL, RST_ZERO);
		rdchk("rate", REG_DEC_RATE, RST_DEC_RATE);
		wr(6'h02, 16'hffff);
		rdchk("unmapped", 6'h02, 16'h0000);
		wr(REG_CH0_WAIT, 16'h1234);
		rdchk("wait0", REG_CH0_WAIT, 16'h1234);
		for (int m = 0; m < 4; m++) begin
			wr(REG_MAIN_CTRL, 16'(m * 5));
			cmp("fullBias", 16'(m), {14'h0, convFullBias});
			cmp("doubleGain", 16'(m), {14'h0, convDoubleGain});
		end
		// Unity comb gain at rate 4: 4^5 * 32/32 / 2^10
		wr(REG_SCALE_SHIFT, 16'h080a);
		wr(REG_CH1_WAIT, RST_ZERO);
		wr(REG_MAIN_CTRL, 16'h0053);
		foreach (rows[r]) begin
			wr(rows[r].a, rows[r].d);
			tick(2);
			near("chan1", attExp(1000, rows[r].k), att1, 2);
			words(10, vi, vq, gap);
			near("streamI", rows[r].eI, vi, 3);
			near("streamQ", rows[r].eQ, vq, 3);
			cmp("gap", 16'(rows[r].eG), 16'(gap));
		end
		// A second code inside the wait window replaces the first and restarts it
		wr(REG_CH1_WAIT, 16'h0014);
		wr(REG_CH1_ATT, 16'h0006);
		tick(8);
		wr(REG_CH1_ATT, 16'h0002);
		tick(20);
		near("chan1Held", 1000, att1, 2);
		tick(1);
		near("chan1Late", 501, att1, 2);
		level.ch1 = 12'd600;
		clkEn = 1'b0;
		tick(3);
		near("chan1Frozen", 501, att1, 2);
		clkEn = 1'b1;
		tick(2);
		near("chan1Run", 300, att1, 2);
		wr(REG_CH0_LIMIT, 16'h0100);
		wr(REG_CH1_LIMIT, 16'h07ff);
		level = '{ch1: 12'h000, ch0: 12'h100};
		tick(3);
		wr(REG_EVENT_STATUS, 16'h000f);
		rdchk("status", REG_EVENT_STATUS, 16'h0000);
		level = '{ch1: 12'h7ff, ch0: 12'heff};
		tick(1);
		level = '{ch1: 12'h000, ch0: 12'h100};
		tick(3);
		rdchk("status", REG_EVENT_STATUS, 16'h0006);
		wr(REG_EVENT_STATUS, 16'h0004);
		rdchk("status", REG_EVENT_STATUS, 16'h0002);
		// Fill the output buffer with the consumer stalled, then drain it disabled
		sampleReady = 1'b0;
		tick(200);
		cmp("validFull", 16'h0001, {15'h0, sampleValid});
		wr(REG_MAIN_CTRL, 16'h0003);
		tick(5);
		sampleReady = 1'b1;
		n = 0;
		repeat (40) begin
			if (sampleValid === 1'b1) n++;
			tick(1);
		end
		// The queue holds 16 words and the decimator's stalled output register one more
		cmp("drained", 16'd17, 16'(n));
		cmp("validIdle", 16'h0000, {15'h0, sampleValid});
		wrap_up();
	end
endmodule : if_front_end_bench
`default_nettype wire
